// ==== edge_pulse.v ====
// Rising and falling edge detector for one synchronous input
`timescale 1ns/10ps
module edge_pulse (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Sampled level
  input wire level,
  // One-cycle edge pulses
  output wire rise,
  output wire fall
);

  reg prev;

  // Previous level, cleared at reset so a high level reads as a rise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 1'h0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule // edge_pulse

// ==== period_frequency_counter.v ====
// Counter pair for period and frequency measurement
`timescale 1ns/10ps
`include "period_frequency_counter_consts.vh"

// How it works
// RQ1: Nothing is measured until arm pulses; then one-shot modes take exactly one measurement and sample-clocked mode keeps sampling.
// RQ2: gate_edge_falling picks falling-to-falling gate periods, else rising-to-rising.
// RQ3: Between the two active gate edges the primary counter counts the chosen source edges.
// RQ4: The result is the raw source edge count, so source period times count is the gate period.
// RQ5: The user keeps the input at least twice the sample clock rate so a full period fits.
// RQ6: In sample-clocked mode the interval is one sample clock period whatever the input does.
// RQ7: In large-range mode the interval is N input periods, so it moves with input frequency.
// RQ8: In high-frequency mode the measurement ends after a fixed gating interval of timebase ticks.
// RQ9: High-frequency gating comes from the second counter unless an external gate is chosen.
// RQ10: Large-range mode uses both counters: one divides the input, one times the pulse.
// RQ11: The two counters here form one fixed pair, primary with its partner only.
// RQ12: Averaging sample mode counts input edges and timebase ticks over each sample period.
// RQ13: Without averaging each sample reports only the input period completed just before it.
// RQ14: A finished one-shot result holds with done high until read_ack or a new arm; sample-clocked results are replaced at each sample edge.
module period_frequency_counter #(
  parameter W = `COUNT_WIDTH_DEFAULT
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Host control
  input wire arm,
  input wire read_ack,
  input wire [`MODE_WIDTH-1:0] mode,
  input wire gate_edge_falling,
  input wire source_edge_falling,
  input wire frequency_averaging_select,
  input wire use_external_gate,
  input wire [W-1:0] divide_count,
  input wire [W-1:0] gate_interval_count,
  // Measured signals
  input wire source_in,
  input wire gate_in,
  input wire timebase_in,
  input wire sample_clk_in,
  // Results and status
  output reg [W-1:0] result_input,
  output reg [W-1:0] result_timebase,
  output reg done,
  output reg busy,
  output reg overflow
);

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  wire src_rise;
  wire src_fall;
  wire gate_rise;
  wire gate_fall;
  wire tb_rise;
  wire samp_rise;

  edge_pulse u_src (.clk(clk), .rst(rst), .level(source_in), .rise(src_rise), .fall(src_fall));
  edge_pulse u_gate (.clk(clk), .rst(rst), .level(gate_in), .rise(gate_rise), .fall(gate_fall));
  edge_pulse u_tb (.clk(clk), .rst(rst), .level(timebase_in), .rise(tb_rise), .fall());
  edge_pulse u_samp (.clk(clk), .rst(rst), .level(sample_clk_in), .rise(samp_rise), .fall());

  // ------------------------------------------------------------
  // Configuration held from arm
  // ------------------------------------------------------------
  reg [`STATE_WIDTH-1:0] state;
  reg [`MODE_WIDTH-1:0] cur_mode;
  reg gate_fall_sel;
  reg src_fall_sel;
  reg averaging;
  reg ext_gate;
  reg [W-1:0] cnt_a;
  reg [W-1:0] cnt_b;
  reg [W-1:0] last_period;
  reg have_edge;
  reg period_seen;

  // Active edge selection follows the settings captured at arm
  wire src_p = src_fall_sel ? src_fall : src_rise; // RQ3
  wire gate_act = gate_fall_sel ? gate_fall : gate_rise; // RQ2
  wire gate_inact = gate_fall_sel ? gate_rise : gate_fall;
  wire [W-1:0] one = {{(W-1){1'h0}}, 1'h1};
  wire [W-1:0] cnt_a_inc = cnt_a + {{(W-1){1'h0}}, src_p};
  wire [W-1:0] cnt_b_inc = cnt_b + {{(W-1){1'h0}}, tb_rise};
  // Saturation is flagged rather than wrapping so a bad count is never silent
  wire ovf_a = src_p & (&cnt_a);
  wire ovf_b = tb_rise & (&cnt_b);

  // ------------------------------------------------------------
  // Sequencer and counters
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= `ST_IDLE;
      cur_mode <= `MODE_PERIOD;
      gate_fall_sel <= `RESET_FLAG;
      src_fall_sel <= `RESET_FLAG;
      averaging <= `RESET_FLAG;
      ext_gate <= `RESET_FLAG;
      cnt_a <= {W{1'h0}};
      cnt_b <= {W{1'h0}};
      last_period <= {W{1'h0}};
      have_edge <= `RESET_FLAG;
      period_seen <= `RESET_FLAG;
      result_input <= {W{1'h0}};
      result_timebase <= {W{1'h0}};
      done <= `RESET_FLAG;
      busy <= `RESET_FLAG;
      overflow <= `RESET_FLAG;
    end else if (arm) begin
      // Re-arm drops any held result and takes a fresh configuration
      state <= `ST_WAIT_START; // RQ1 RQ14
      cur_mode <= mode;
      gate_fall_sel <= gate_edge_falling;
      src_fall_sel <= source_edge_falling;
      averaging <= frequency_averaging_select;
      ext_gate <= use_external_gate;
      cnt_a <= {W{1'h0}};
      cnt_b <= {W{1'h0}};
      have_edge <= 1'h0;
      period_seen <= 1'h0;
      done <= 1'h0;
      busy <= 1'h1;
      overflow <= 1'h0;
    end else begin
      case (state)
        `ST_IDLE: begin
          busy <= 1'h0;
        end
        `ST_WAIT_START: begin
          case (cur_mode)
            `MODE_PERIOD: begin
              if (gate_act) begin
                state <= `ST_MEASURE; // RQ1
              end
            end
            `MODE_HIGH_FREQ: begin
              // External gate of known width replaces the partner counter
              if (!ext_gate || gate_act) begin
                state <= `ST_MEASURE; // RQ9
              end
            end
            `MODE_LARGE_RANGE: begin
              // First input edge opens the divided-down pulse
              if (src_p) begin
                state <= `ST_MEASURE; // RQ10
              end
            end
            default: begin
              // Sample mode aligns to the first sample clock edge
              if (samp_rise) begin
                state <= `ST_MEASURE; // RQ6
              end
            end
          endcase
        end
        `ST_MEASURE: begin
          if (ovf_a || ovf_b) begin
            overflow <= 1'h1;
          end
          case (cur_mode)
            `MODE_PERIOD: begin
              if (gate_act) begin
                // Closing edge ends the one period; source edge in this cycle is not counted
                result_input <= cnt_a; // RQ3 RQ4
                done <= 1'h1; // RQ14
                busy <= 1'h0;
                state <= `ST_DONE; // RQ1
              end else begin
                cnt_a <= ovf_a ? cnt_a : cnt_a_inc; // RQ3
              end
            end
            `MODE_HIGH_FREQ: begin
              if (ext_gate ? gate_inact : (cnt_b == gate_interval_count)) begin
                result_input <= cnt_a; // RQ8
                result_timebase <= cnt_b;
                done <= 1'h1; // RQ14
                busy <= 1'h0;
                state <= `ST_DONE;
              end else begin
                cnt_a <= ovf_a ? cnt_a : cnt_a_inc;
                // Partner counter times the fixed gating interval
                cnt_b <= ovf_b ? cnt_b : cnt_b_inc; // RQ9 RQ11
              end
            end
            `MODE_LARGE_RANGE: begin
              if (src_p && (cnt_a_inc == divide_count)) begin
                // Pulse of N input periods closes: interval follows input frequency
                result_input <= cnt_a_inc; // RQ7
                result_timebase <= cnt_b; // RQ10
                done <= 1'h1; // RQ14
                busy <= 1'h0;
                state <= `ST_DONE;
              end else begin
                cnt_a <= ovf_a ? cnt_a : cnt_a_inc; // RQ10
                cnt_b <= ovf_b ? cnt_b : cnt_b_inc; // RQ10 RQ11
              end
            end
            default: begin
              if (samp_rise) begin
                if (averaging) begin
                  result_input <= cnt_a; // RQ12
                  result_timebase <= cnt_b; // RQ12
                  cnt_a <= {{(W-1){1'h0}}, src_p};
                  cnt_b <= {{(W-1){1'h0}}, tb_rise};
                end else begin
                  // Only the last whole period before this edge is reported
                  result_input <= one; // RQ13
                  result_timebase <= last_period; // RQ13
                  if (!period_seen) begin
                    overflow <= 1'h1; // RQ5
                  end
                  period_seen <= 1'h0;
                end
                done <= 1'h1; // RQ6 RQ14
              end else if (read_ack) begin
                done <= 1'h0;
              end
              if (!averaging) begin
                if (src_p) begin
                  if (have_edge) begin
                    last_period <= cnt_b; // RQ13
                    period_seen <= 1'h1;
                  end
                  have_edge <= 1'h1;
                  cnt_b <= {W{1'h0}};
                end else begin
                  cnt_b <= ovf_b ? cnt_b : cnt_b_inc;
                end
              end else if (!samp_rise) begin
                cnt_a <= ovf_a ? cnt_a : cnt_a_inc; // RQ12
                cnt_b <= ovf_b ? cnt_b : cnt_b_inc; // RQ12 RQ11
              end
            end
          endcase
        end
        `ST_DONE: begin
          // Result stands until the host takes it
          if (read_ack) begin
            done <= 1'h0; // RQ14
            state <= `ST_IDLE;
          end
        end
        default: begin
          state <= `ST_IDLE;
        end
      endcase
    end
  end

endmodule // period_frequency_counter

// ==== period_frequency_counter_asserts.sv ====
// Port checks for the counter pair
`timescale 1ns/10ps
module period_frequency_counter_asserts #(
  parameter W = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Host control
  input wire arm,
  input wire read_ack,
  input wire [1:0] mode,
  input wire frequency_averaging_select,
  input wire use_external_gate,
  input wire [W-1:0] divide_count,
  input wire [W-1:0] gate_interval_count,
  // Results and status
  input wire [W-1:0] result_input,
  input wire [W-1:0] result_timebase,
  input wire done,
  input wire busy,
  input wire overflow
);
  reg [1:0] lm;
  reg lavg;
  reg lext;
  reg armed;
  reg [W-1:0] ln;
  reg [W-1:0] lgi;
  // Config as taken at arm, since the ports may move afterwards
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lm <= 2'h0;
      armed <= 1'h0;
    end else if (arm) begin
      lm <= mode;
      lavg <= frequency_averaging_select;
      lext <= use_external_gate;
      ln <= divide_count;
      lgi <= gate_interval_count;
      armed <= 1'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // --------------------------------
  // Assertions
  // --------------------------------
  a_arm_starts: assert property (arm |=> busy && !done && !overflow)
    else $error("arm did not start a run");
  a_no_early_done: assert property (!armed |-> !done)
    else $error("done before any arm");
  a_single_run: assert property (done && lm != 2'h3 |-> !busy)
    else $error("busy after one-shot result");
  a_result_hold: assert property (done && !arm && !read_ack && lm != 2'h3 |=>
    done && $stable(result_input) && $stable(result_timebase))
    else $error("result moved while held");
  a_ack_clears: assert property (done && read_ack && !arm && lm != 2'h3 |=> !done)
    else $error("read_ack left done set");
  a_large_n: assert property (done && lm == 2'h2 |-> result_input == ln)
    else $error("large range input count wrong");
  a_hf_interval: assert property (done && lm == 2'h1 && !lext |-> result_timebase == lgi)
    else $error("gating interval wrong");
  a_single_period: assert property (done && lm == 2'h3 && !lavg |-> result_input == 1)
    else $error("single period count not one");
  a_sample_runs: assert property (lm == 2'h3 && busy && !arm |=> busy)
    else $error("sample mode stopped");
  c_period: cover property (done && lm == 2'h0);
  c_large: cover property (done && lm == 2'h2);
  c_avg: cover property (done && lm == 2'h3 && lavg);
endmodule // period_frequency_counter_asserts

bind period_frequency_counter period_frequency_counter_asserts #(.W(W))
  u_period_frequency_counter_asserts (.clk, .rst, .arm, .read_ack, .mode,
  .frequency_averaging_select, .use_external_gate, .divide_count, .gate_interval_count,
  .result_input, .result_timebase, .done, .busy, .overflow);

// ==== period_frequency_counter_consts.vh ====
// Constants shared by the counter pair: modes, states, widths
`ifndef PERIOD_FREQUENCY_COUNTER_CONSTS_VH
`define PERIOD_FREQUENCY_COUNTER_CONSTS_VH

// ------------------------------------------------------------
// Measurement modes (mode input)
// ------------------------------------------------------------
`define MODE_WIDTH 2
`define MODE_PERIOD 2'h0
`define MODE_HIGH_FREQ 2'h1
`define MODE_LARGE_RANGE 2'h2
`define MODE_SAMPLE_CLOCKED 2'h3

// ------------------------------------------------------------
// Sequencer states
// ------------------------------------------------------------
`define STATE_WIDTH 2
`define ST_IDLE 2'h0
`define ST_WAIT_START 2'h1
`define ST_MEASURE 2'h2
`define ST_DONE 2'h3

// ------------------------------------------------------------
// Default counter width and reset values
// ------------------------------------------------------------
`define COUNT_WIDTH_DEFAULT 32
`define RESET_FLAG 1'h0

`endif

// ==== period_frequency_counter_tb_top.sv ====
// Self-checking bench for the counter pair
`timescale 1ns/10ps
module period_frequency_counter_tb_top;
  reg clk = 1'h0;
  reg rst = 1'h1;
  reg arm = 1'h0;
  reg read_ack = 1'h0;
  reg [1:0] mode = 2'h0;
  reg gate_edge_falling = 1'h0;
  reg source_edge_falling = 1'h0;
  reg frequency_averaging_select = 1'h0;
  reg use_external_gate = 1'h0;
  reg [15:0] divide_count = 16'h0005;
  reg [15:0] gate_interval_count = 16'h0032;
  reg [7:0] src_half = 8'h03;
  reg [7:0] gate_half = 8'h1E;
  reg [7:0] smp_half = 8'h32;
  wire source_in, gate_in, timebase_in, sample_clk_in, done, busy, overflow;
  wire [15:0] result_input, result_timebase;
  integer fails = 0;
  integer compares = 0;
  integer cycles = 0;
  integer i;
  integer h;
  always #12.5 clk = ~clk;
  signal_source_model u_signal_source_model (.clk, .src_half, .gate_half, .smp_half,
    .source_in, .gate_in, .timebase_in, .sample_clk_in);
  period_frequency_counter #(.W(16)) u_period_frequency_counter (.clk, .rst, .arm,
    .read_ack, .mode, .gate_edge_falling, .source_edge_falling, .frequency_averaging_select,
    .use_external_gate, .divide_count, .gate_interval_count, .source_in, .gate_in,
    .timebase_in, .sample_clk_in, .result_input, .result_timebase, .done, .busy, .overflow);
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task chk(input [8*12:1] what, input [15:0] lo, input [15:0] hi, input [15:0] got);
    begin
      compares = compares + 1;
      if ((got >= lo && got <= hi) !== 1'h1) begin
        fails = fails + 1;
        $display("Error %0s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
    end
  endtask
  // Wave change, then settle so no half-period glitch meets an arm
  task set_wave(input integer s, input integer g);
    begin
      @(posedge clk);
      src_half <= s[7:0];
      gate_half <= g[7:0];
      repeat (200) @(posedge clk);
    end
  endtask
  task measure(input [1:0] m, input g, input s, input a, input x);
    integer n;
    begin
      @(posedge clk);
      {mode, gate_edge_falling, source_edge_falling} <= {m, g, s};
      {frequency_averaging_select, use_external_gate, arm} <= {a, x, 1'h1};
      @(posedge clk);
      arm <= 1'h0;
      n = 0;
      @(negedge clk);
      while (done !== 1'h1 && n < 2000) begin
        @(negedge clk);
        n = n + 1;
      end
      chk("done", 1, 1, done);
      // One-shot modes drop busy with the result; sample mode keeps running
      chk("busy", m == 2'h3, m == 2'h3, busy);
    end
  endtask
  task ack;
    begin
      @(posedge clk);
      read_ack <= 1'h1;
      @(posedge clk);
      read_ack <= 1'h0;
      @(negedge clk);
      chk("done clear", 0, 0, done);
    end
  endtask
  task stop_test;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task test_modes;
    begin
      repeat (200) @(negedge clk);
      chk("idle done", 0, 0, done);
      for (i = 0; i < 8; i = i + 1) begin
        h = i[2] ? 2 : 3;
        set_wave(h, 20 * h);
        measure(2'h0, i[0], i[1], 1'h0, 1'h0);
        // Gate period 40h cycles over source period 2h cycles gives 20 edges
        chk("period", 20, 20, result_input);
        chk("period ovf", 0, 0, overflow);
        ack;
      end
      // A finished one-shot must not start a second measurement by itself
      repeat (300) @(negedge clk);
      chk("one shot", 0, 0, done);
      $display("test period finished");
      for (h = 2; h < 4; h = h + 1) begin
        set_wave(h, 30);
        measure(2'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        chk("hf ticks", 50, 50, result_timebase);
        chk("hf input", 50 / h - 1, 50 / h + 1, result_input);
        ack;
        measure(2'h1, 1'h0, 1'h0, 1'h0, 1'h1);
        chk("ext gate", 15 / h, 15 / h + 1, result_input);
        ack;
        measure(2'h2, 1'h0, 1'h0, 1'h0, 1'h0);
        chk("large n", 5, 5, result_input);
        chk("large ticks", 5 * h - 1, 5 * h + 1, result_timebase);
        ack;
        measure(2'h3, 1'h0, 1'h0, 1'h1, 1'h0);
        chk("avg ticks", 49, 51, result_timebase);
        chk("avg input", 50 / h - 1, 50 / h + 1, result_input);
      end
      $display("test frequency finished");
      set_wave(4, 30);
      measure(2'h3, 1'h0, 1'h0, 1'h0, 1'h0);
      chk("single in", 1, 1, result_input);
      chk("single tick", 3, 5, result_timebase);
      chk("single ovf", 0, 0, overflow);
      $display("test single period finished");
      // Input slower than the sample clock: no whole period fits, so overflow
      set_wave(100, 30);
      measure(2'h3, 1'h0, 1'h0, 1'h0, 1'h0);
      chk("slow ovf", 1, 1, overflow);
      $display("test slow input finished");
    end
  endtask
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    test_modes;
    stop_test;
  end
endmodule // period_frequency_counter_tb_top

// ==== signal_source_model.sv ====
// Model of the measured signal sources
`timescale 1ns/10ps
module signal_source_model (
  // Clock
  input wire clk,
  // Half periods in clk cycles
  input wire [7:0] src_half,
  input wire [7:0] gate_half,
  input wire [7:0] smp_half,
  // Generated levels
  output reg source_in = 1'h0,
  output reg gate_in = 1'h0,
  output reg timebase_in = 1'h0,
  output reg sample_clk_in = 1'h0
);
  integer cyc = 0;
  // Source leads by one cycle so its edges never meet gate edges
  always @(posedge clk) begin
    cyc <= cyc + 1;
    source_in <= ((cyc + 1) / src_half) % 2 != 0;
    gate_in <= (cyc / gate_half) % 2 != 0;
    sample_clk_in <= (cyc / smp_half) % 2 != 0;
    timebase_in <= cyc % 2 != 0;
  end
endmodule // signal_source_model
